// ---- hw/cwrs_sequencer.sv ----
/*
  Write request time-state sequencer of the storage controller cache
  control. Assumes arbitration, writeback, refill and fail-recovery
  sequences sit outside; writeback and refill report back with done pulses.
*/
module cwrs_sequencer
  import cwrs_pkg::*;
#(
  parameter int SEL_LO = BUF_SEL_LO
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic writeReq,
  input wire logic [VADDR_W-1:0] virtualAddr,
  input wire logic userSpaceFlag,
  input wire logic reqPaged,
  input wire logic reqNeedPublic,
  input wire logic legacyPaging,
  input wire logic lookupEnable,
  input wire logic cacheLoadQualifier,
  input wire logic cachePresent,
  input wire logic busDiagFlag,
  input wire logic [PADDR_W-PAGE_W-1:0] entryPhysPage,
  input wire logic entryUser,
  input wire logic [SECT_W-1:0] entrySect,
  input wire logic entryInvalid,
  input wire logic [KEY_N-1:0] entryKeys,
  input wire logic anyValidMatch,
  input wire logic victimHasDirty,
  input wire logic coreFillSameLine,
  input wire logic coreBusy,
  input wire logic phaseChangeWarning,
  input wire logic writebackDone,
  input wire logic refillDone,
  input wire logic memoryAcknowledge,
  input wire logic [WORD_W-1:0] faultWord,
  output logic [PADDR_W-1:0] physicalAddr,
  output logic [VADDR_W-1:0] lookupIndex,
  output logic responseSignal,
  output logic faultHold,
  output logic faultHandleSignal,
  output logic pageFailSignal,
  output logic [WORD_W-1:0] busRegister,
  output logic dataClearDoneState,
  output logic forceMatch,
  output logic useTableUpdate,
  output logic cacheWrite,
  output logic dirLoad,
  output logic victimClear,
  output logic writebackStart,
  output logic refillStart,
  output logic [BUF_N-1:0] bufferHold,
  output logic coreWriteStart,
  output logic [1:0] bufferSelect,
  output logic coreCycleActive,
  output logic cycleLatch,
  output logic reqPending
);
  // Select pair must sit inside the physical address
  if (SEL_LO < 0 || SEL_LO > PADDR_W - 2)
  begin : g_bad_sel
    $error("Buffer select position out of range");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    cwrs_state_t st;
    cwrs_path_t path;
    logic pend;
    logic cyc;
    logic refilled;
    logic waitWb;
    logic waitRf;
    logic [PADDR_W-1:0] pa;
    logic resp;
    logic hold;
    logic handle;
    logic pfSig;
    logic [WORD_W-1:0] busReg;
    logic clrDone;
    logic force_;
    logic useUpd;
    logic cwr;
    logic dirLd;
    logic vclr;
    logic wbStart;
    logic rfStart;
    logic [BUF_N-1:0] bhold;
    logic coreStart;
  } cwrs_seq_t;
  cwrs_seq_t s_q, s_d;

  logic pageEntryHit, refLegal, pageCacheable, qBusy, qLoad;
  logic [1:0] qSel, loadSel;

  assign lookupIndex = virtualAddr;
  assign loadSel = s_q.pa[SEL_LO +: 2];
  assign qLoad = (s_q.st == ST_ONE_WR);

  cwrs_entry_check u_check (
    .entryUser(entryUser),
    .entrySect(entrySect),
    .entryInvalid(entryInvalid),
    .entryKeys(entryKeys),
    .userSpaceFlag(userSpaceFlag),
    .reqSect(virtualAddr[VADDR_W-1 -: SECT_W]),
    .reqNeedPublic(reqNeedPublic),
    .pageEntryHit(pageEntryHit),
    .refLegal(refLegal),
    .pageCacheable(pageCacheable)
  );

  cwrs_buf_queue u_queue (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(qLoad),
    .loadSel(loadSel),
    .memoryAcknowledge(memoryAcknowledge),
    .queueBusy(qBusy),
    .bufferSelect(qSel)
  );

  // Path choice at the decision state
  function automatic cwrs_path_t choose_path(
    input logic paged, input logic hit, input logic legal,
    input logic cacheable, input logic refilled, input logic legacy,
    input logic look, input logic load, input logic present,
    input logic diag, input logic anyMatch, input logic dirty);
    logic useCache;
    begin
      useCache = 1'b0;
      if (paged && !hit)
        return (legacy && !refilled) ? PATH_REFILL : PATH_FAIL;
      if (paged && !legal)
        return PATH_FAIL;
      if (!look || !present || diag)
        return PATH_ONE;
      useCache = load && (!paged || cacheable);
      if (anyMatch)
        return PATH_HIT;
      if (!useCache)
        return PATH_ONE;
      return dirty ? PATH_WBACK : PATH_CLEAR;
    end
  endfunction : choose_path

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.resp = 1'b0;
    s_d.pfSig = 1'b0;
    s_d.useUpd = 1'b0;
    s_d.cwr = 1'b0;
    s_d.dirLd = 1'b0;
    s_d.vclr = 1'b0;
    s_d.wbStart = 1'b0;
    s_d.rfStart = 1'b0;
    s_d.coreStart = 1'b0;
    s_d.bhold = '1;
    if (writeReq)
      s_d.pend = 1'b1;
    if (s_q.waitWb && writebackDone)
      s_d.waitWb = 1'b0;
    if (s_q.waitRf && refillDone)
      s_d.waitRf = 1'b0;
    case (s_q.st)
      ST_IDLE:
      begin
        s_d.cyc = 1'b0;
        if (s_q.pend && !s_q.waitWb && !s_q.waitRf)
          s_d.st = ST_READY;
        else if (!s_q.pend)
          s_d.refilled = 1'b0;
      end
      ST_READY:
      begin
        // clear pending, set cycle latch, form address
        s_d.pend = writeReq;
        s_d.cyc = 1'b1;
        s_d.hold = 1'b0;
        s_d.handle = 1'b0;
        s_d.pa = reqPaged ?
          {entryPhysPage, virtualAddr[PAGE_W-1:0]} :
          PADDR_W'(virtualAddr);
        s_d.st = ST_T0;
      end
      ST_T0: s_d.st = ST_T1;
      ST_T1: s_d.st = ST_T2;
      ST_T2:
      begin
        s_d.path = choose_path(reqPaged, pageEntryHit, refLegal,
          pageCacheable, s_q.refilled, legacyPaging, lookupEnable,
          cacheLoadQualifier, cachePresent, busDiagFlag, anyValidMatch,
          victimHasDirty);
        s_d.st = ST_T3;
        if (s_d.path == PATH_HIT)
        begin
          // write-check with clear-done and use update
          s_d.clrDone = 1'b1;
          s_d.useUpd = 1'b1;
        end
        else if (s_d.path == PATH_CLEAR)
          s_d.st = ST_CLR_WR;
        else if (s_d.path == PATH_WBACK)
        begin
          s_d.wbStart = 1'b1;
          s_d.waitWb = 1'b1;
          s_d.st = ST_RETRY;
        end
        else if (s_d.path == PATH_FAIL)
        begin
          // fail signalled at first fail state
          s_d.pfSig = 1'b1;
          s_d.st = ST_PF_T1;
        end
      end
      ST_T3:
      begin
        s_d.st = ST_IDLE;
        if (s_q.path == PATH_HIT || s_q.path == PATH_CLEAR)
        begin
          // refuse while core fills same line
          if (coreFillSameLine)
          begin
            s_d.clrDone = 1'b0;
            s_d.force_ = 1'b0;
            s_d.st = ST_RETRY;
          end
          else
            s_d.st = ST_WR_T4;
        end
        else if (s_q.path == PATH_REFILL)
        begin
          s_d.rfStart = 1'b1;
          s_d.waitRf = 1'b1;
          s_d.refilled = 1'b1;
          s_d.st = ST_RETRY;
        end
        else if (s_q.path == PATH_ONE)
          s_d.st = (coreBusy || qBusy) ? ST_RETRY : ST_ONE_WR;
      end
      ST_WR_T4:
      begin
        // write data, set valid and written, respond
        s_d.cwr = 1'b1;
        s_d.resp = 1'b1;
        s_d.clrDone = 1'b0;
        s_d.force_ = 1'b0;
        s_d.refilled = 1'b0;
        s_d.st = ST_IDLE;
      end
      ST_CLR_WR:
      begin
        if (coreFillSameLine)
          s_d.st = ST_RETRY;
        else
        begin
          s_d.st = ST_CLR_1;
          s_d.dirLd = 1'b1;
          s_d.useUpd = 1'b1;
        end
      end
      ST_CLR_1:
      begin
        s_d.vclr = 1'b1;
        s_d.st = ST_CLR_3;
      end
      ST_CLR_3:
      begin
        // force match on victim, then third state
        s_d.clrDone = 1'b1;
        s_d.force_ = 1'b1;
        s_d.st = ST_T3;
      end
      ST_ONE_WR:
      begin
        // drop the selected buffer hold for one clock
        s_d.st = ST_XFER;
      end
      ST_XFER:
      begin
        if (phaseChangeWarning)
          s_d.st = ST_XFER_T4;
      end
      ST_XFER_T4:
      begin
        s_d.coreStart = 1'b1;
        s_d.resp = 1'b1;
        s_d.refilled = 1'b0;
        s_d.st = ST_IDLE;
      end
      ST_PF_T1: s_d.st = ST_PF_T3;
      ST_PF_T3:
      begin
        // fault word to bus register and hold
        s_d.busReg = faultWord;
        s_d.hold = 1'b1;
        s_d.handle = !legacyPaging;
        s_d.resp = 1'b1;
        s_d.refilled = 1'b0;
        s_d.st = ST_IDLE;
      end
      ST_RETRY:
      begin
        s_d.pend = 1'b1;
        s_d.st = ST_IDLE;
      end
      default: s_d.st = ST_IDLE;
    endcase
    // hold drop is registered so it lasts exactly one clock
    if (s_q.st == ST_ONE_WR)
      s_d.bhold = '1;
    else if (s_d.st == ST_ONE_WR)
      s_d.bhold[s_q.pa[SEL_LO +: 2]] = 1'b0;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.path <= PATH_NONE;
      s_q.busReg <= FAULT_WORD_RST;
      s_q.bhold <= '1;
    end
    else
      s_q <= s_d;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign physicalAddr = s_q.pa;
  assign responseSignal = s_q.resp;
  assign faultHold = s_q.hold;
  assign faultHandleSignal = s_q.handle;
  assign pageFailSignal = s_q.pfSig;
  assign busRegister = s_q.busReg;
  assign dataClearDoneState = s_q.clrDone;
  assign forceMatch = s_q.force_;
  assign useTableUpdate = s_q.useUpd;
  assign cacheWrite = s_q.cwr;
  assign dirLoad = s_q.dirLd;
  assign victimClear = s_q.vclr;
  assign writebackStart = s_q.wbStart;
  assign refillStart = s_q.rfStart;
  assign bufferHold = s_q.bhold;
  assign coreWriteStart = s_q.coreStart;
  // queue drives select; acknowledge ends the core cycle
  assign bufferSelect = qSel;
  assign coreCycleActive = qBusy;
  assign cycleLatch = s_q.cyc;
  assign reqPending = s_q.pend;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_ready_to_t0: assert property (s_q.st == ST_READY |=>
    s_q.st == ST_T0 && s_q.cyc) else $error("Ready did not enter T0");
  a_delay_chain: assert property (s_q.st == ST_T0 |=>
    s_q.st == ST_T1 ##1 s_q.st == ST_T2) else $error("Delay chain broken");
  a_decide_t3: assert property (s_q.st == ST_T2 |=>
    s_q.st inside {ST_T3, ST_CLR_WR, ST_RETRY, ST_PF_T1})
    else $error("Bad state after decision");
  a_hit_clrdone: assert property (s_q.st == ST_T2 &&
    s_d.path == PATH_HIT |=> s_q.clrDone && s_q.useUpd)
    else $error("Hit without clear-done");
  a_busy_retry: assert property (s_q.st == ST_T3 &&
    s_q.path == PATH_HIT && coreFillSameLine |=> s_q.st == ST_RETRY)
    else $error("Write not refused");
  a_write_resp: assert property (s_q.st == ST_WR_T4 |=>
    s_q.cwr && s_q.resp && s_q.st == ST_IDLE)
    else $error("Cache write missing response");
  a_clear_force: assert property (s_q.st == ST_CLR_1 |=>
    s_q.vclr ##1 s_q.force_ && s_q.st == ST_T3)
    else $error("Victim not forced");
  a_fault_hold: assert property (s_q.st == ST_PF_T3 |=>
    s_q.hold && s_q.busReg == $past(faultWord))
    else $error("Fault word not loaded");
  a_hold_pulse: assert property ($fell(s_q.bhold[loadSel]) |=>
    s_q.bhold == '1 && qBusy) else $error("Hold drop not one clock");
  a_ack_clear: assert property (memoryAcknowledge && !qLoad |=>
    !qBusy) else $error("Queue not cleared");
  a_retry_pend: assert property (s_q.st == ST_RETRY |=>
    s_q.pend) else $error("Retry lost request");

  c_hit_write: cover property (s_q.st == ST_WR_T4 && s_q.path == PATH_HIT);
  c_clear_path: cover property (s_q.st == ST_CLR_3);
  c_one_word: cover property (s_q.st == ST_XFER_T4);
  c_page_fail: cover property (s_q.st == ST_PF_T3);
endmodule : cwrs_sequencer

// ---- hw/cwrs_pkg.sv ----
/*
  Constants, state encodings and field positions for the cache write
  request sequencer. Assumes one 25 MHz clock and active-high async reset.
*/
package cwrs_pkg;
  localparam int VADDR_W = 27;
  localparam int PADDR_W = 36;
  localparam int PAGE_W = 9;
  localparam int SECT_W = 5;
  localparam int WORD_W = 36;
  localparam int BUF_N = 4;
  // Buffer select bits of the physical address, numbered from bit 0 = LSB
  localparam int BUF_SEL_LO = 0;
  // Page entry field positions
  localparam int KEY_ACCESS = 0;
  localparam int KEY_WRITABLE = 1;
  localparam int KEY_PUBLIC = 2;
  localparam int KEY_SOFTWARE = 3;
  localparam int KEY_CACHE = 4;
  localparam int KEY_N = 5;
  localparam logic [WORD_W-1:0] FAULT_WORD_RST = 36'h000000000;

  typedef enum logic [15:0] {
    ST_IDLE = 16'h0001,
    ST_READY = 16'h0002,
    ST_T0 = 16'h0004,
    ST_T1 = 16'h0008,
    ST_T2 = 16'h0010,
    ST_T3 = 16'h0020,
    ST_WR_T4 = 16'h0040,
    ST_CLR_WR = 16'h0080,
    ST_CLR_1 = 16'h0100,
    ST_CLR_3 = 16'h0200,
    ST_ONE_WR = 16'h0400,
    ST_XFER = 16'h0800,
    ST_XFER_T4 = 16'h1000,
    ST_PF_T1 = 16'h2000,
    ST_PF_T3 = 16'h4000,
    ST_RETRY = 16'h8000
  } cwrs_state_t;

  typedef enum logic [2:0] {
    PATH_NONE = 3'h0,
    PATH_HIT = 3'h1,
    PATH_CLEAR = 3'h2,
    PATH_WBACK = 3'h3,
    PATH_REFILL = 3'h4,
    PATH_FAIL = 3'h5,
    PATH_ONE = 3'h6
  } cwrs_path_t;
endpackage : cwrs_pkg

// ---- hw/cwrs_entry_check.sv ----
/*
  Page entry legality and match check, purely combinational.
  Assumes the stored entry comes from a lookup indexed by virtual address.
*/
module cwrs_entry_check
  import cwrs_pkg::*;
(
  input wire logic entryUser,
  input wire logic [SECT_W-1:0] entrySect,
  input wire logic entryInvalid,
  input wire logic [KEY_N-1:0] entryKeys,
  input wire logic userSpaceFlag,
  input wire logic [SECT_W-1:0] reqSect,
  input wire logic reqNeedPublic,
  output logic pageEntryHit,
  output logic refLegal,
  output logic pageCacheable
);
  always_comb
  begin
    pageEntryHit = (entryUser == userSpaceFlag) && (entrySect == reqSect) &&
                   !entryInvalid;
    refLegal = entryKeys[KEY_ACCESS] && entryKeys[KEY_WRITABLE] &&
               (entryKeys[KEY_PUBLIC] || !reqNeedPublic);
    pageCacheable = entryKeys[KEY_CACHE];
  end
endmodule : cwrs_entry_check

// ---- hw/cwrs_buf_queue.sv ----
/*
  Write-request queue remembering which memory buffer holds the word.
  Assumes acknowledge arrives only while a core write is outstanding.
*/
module cwrs_buf_queue
  import cwrs_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [1:0] loadSel,
  input wire logic memoryAcknowledge,
  output logic queueBusy,
  output logic [1:0] bufferSelect
);
  typedef struct packed {
    logic busy;
    logic [1:0] sel;
  } cwrs_queue_t;
  cwrs_queue_t s_q, s_d;
  always_comb
  begin
    s_d = s_q;
    if (memoryAcknowledge)
      s_d.busy = 1'b0;
    // record loaded buffer; a new load wins over a clear
    if (load)
    begin
      s_d.busy = 1'b1;
      s_d.sel = loadSel;
    end
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  assign queueBusy = s_q.busy;
  assign bufferSelect = s_q.sel;
endmodule : cwrs_buf_queue

// ---- bench/cwrs_mem_model.sv ----
/*
  Model of the memory side and the outer writeback and refill sequences.
  Assumes one shared clock and one-cycle start strobes from the sequencer.
*/
module cwrs_mem_model
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic coreWriteStart,
  input wire logic writebackStart,
  input wire logic refillStart,
  input wire logic [7:0] ackDelay,
  output logic memoryAcknowledge,
  output logic writebackDone,
  output logic refillDone,
  output logic phaseChangeWarning
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ackCnt_q;
  logic [2:0] wbCnt_q;
  logic [2:0] rfCnt_q;
  logic [2:0] phase_q;
  // ----------------------------------------
  // Memory and outer sequences
  // ----------------------------------------
  // Slow acknowledge keeps the core cycle open after the sequencer is idle
  // acknowledge ends write
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ackCnt_q <= 8'h00;
      wbCnt_q <= 3'h0;
      rfCnt_q <= 3'h0;
      phase_q <= 3'h0;
      memoryAcknowledge <= 1'b0;
      writebackDone <= 1'b0;
      refillDone <= 1'b0;
      phaseChangeWarning <= 1'b0;
    end
    else
    begin
      phase_q <= phase_q + 3'h1;
      phaseChangeWarning <= (phase_q == 3'h7);
      memoryAcknowledge <= (ackCnt_q == 8'h01);
      writebackDone <= (wbCnt_q == 3'h1);
      refillDone <= (rfCnt_q == 3'h1);
      ackCnt_q <= coreWriteStart ? ackDelay : ackCnt_q - 8'(ackCnt_q != 0);
      wbCnt_q <= writebackStart ? 3'h4 : wbCnt_q - 3'(wbCnt_q != 0);
      rfCnt_q <= refillStart ? 3'h4 : rfCnt_q - 3'(rfCnt_q != 0);
    end
  end
endmodule : cwrs_mem_model

// ---- bench/tb_top.sv ----
/*
  Self-checking bench for the cache write request sequencer.
  Assumes the memory model answers core writes and outer sequences.
*/
`define CHK(got, exp) \
  begin \
    totalChecks++; \
    if ((got) !== (exp)) \
    begin \
      nFail++; \
      $display("BAD %0t got %h want %h", $time, got, exp); \
    end \
  end
module tb_top
  import cwrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LAT_HIT = 8;
  localparam int LAT_CLR = 11;
  logic clk, sys_rst, writeReq, userSpaceFlag, reqPaged, reqNeedPublic;
  logic legacyPaging, lookupEnable, cacheLoadQualifier, cachePresent;
  logic busDiagFlag, entryUser, entryInvalid, anyValidMatch, victimHasDirty;
  logic coreFillSameLine, coreBusy, memoryAcknowledge, writebackDone;
  logic refillDone, phaseChangeWarning, responseSignal, faultHold;
  logic faultHandleSignal, pageFailSignal, dataClearDoneState, forceMatch;
  logic useTableUpdate, cacheWrite, dirLoad, victimClear, writebackStart;
  logic refillStart, coreWriteStart, coreCycleActive, cycleLatch, reqPending;
  logic [VADDR_W-1:0] virtualAddr, lookupIndex;
  logic [PADDR_W-PAGE_W-1:0] entryPhysPage;
  logic [SECT_W-1:0] entrySect;
  logic [KEY_N-1:0] entryKeys;
  logic [WORD_W-1:0] faultWord, busRegister;
  logic [PADDR_W-1:0] physicalAddr;
  logic [BUF_N-1:0] bufferHold, holdSeen;
  logic [1:0] bufferSelect;
  logic [10:0] seen;
  logic [7:0] ackDelay;
  int nFail, totalChecks, holdCnt, lat;

  cwrs_sequencer dut_u (.clk(clk), .sys_rst(sys_rst), .writeReq(writeReq),
    .virtualAddr(virtualAddr), .userSpaceFlag(userSpaceFlag),
    .reqPaged(reqPaged), .reqNeedPublic(reqNeedPublic),
    .legacyPaging(legacyPaging), .lookupEnable(lookupEnable),
    .cacheLoadQualifier(cacheLoadQualifier), .cachePresent(cachePresent),
    .busDiagFlag(busDiagFlag), .entryPhysPage(entryPhysPage),
    .entryUser(entryUser), .entrySect(entrySect),
    .entryInvalid(entryInvalid), .entryKeys(entryKeys),
    .anyValidMatch(anyValidMatch), .victimHasDirty(victimHasDirty),
    .coreFillSameLine(coreFillSameLine), .coreBusy(coreBusy),
    .phaseChangeWarning(phaseChangeWarning), .writebackDone(writebackDone),
    .refillDone(refillDone), .memoryAcknowledge(memoryAcknowledge),
    .faultWord(faultWord), .physicalAddr(physicalAddr),
    .lookupIndex(lookupIndex), .responseSignal(responseSignal),
    .faultHold(faultHold), .faultHandleSignal(faultHandleSignal),
    .pageFailSignal(pageFailSignal), .busRegister(busRegister),
    .dataClearDoneState(dataClearDoneState), .forceMatch(forceMatch),
    .useTableUpdate(useTableUpdate), .cacheWrite(cacheWrite),
    .dirLoad(dirLoad), .victimClear(victimClear),
    .writebackStart(writebackStart), .refillStart(refillStart),
    .bufferHold(bufferHold), .coreWriteStart(coreWriteStart),
    .bufferSelect(bufferSelect), .coreCycleActive(coreCycleActive),
    .cycleLatch(cycleLatch), .reqPending(reqPending));

  cwrs_mem_model model_u (.clk(clk), .sys_rst(sys_rst),
    .coreWriteStart(coreWriteStart), .writebackStart(writebackStart),
    .refillStart(refillStart), .ackDelay(ackDelay),
    .memoryAcknowledge(memoryAcknowledge), .writebackDone(writebackDone),
    .refillDone(refillDone), .phaseChangeWarning(phaseChangeWarning));

  // ----------------------------------------
  // Clock and strobe monitor
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Sticky record, since most outputs are one-cycle pulses
  always @(posedge clk)
  begin
    seen <= seen | {~&bufferHold, coreWriteStart, pageFailSignal, refillStart,
      writebackStart, forceMatch, victimClear, dirLoad, useTableUpdate,
      dataClearDoneState, cacheWrite};
    holdSeen <= holdSeen | ~bufferHold;
    holdCnt <= holdCnt + int'(!(&bufferHold));
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic conclude();
    begin
      $display("checks %0d failures %0d", totalChecks, nFail);
      if (nFail == 0 && totalChecks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask : conclude

  task automatic limit(input int n, input int max);
    begin
      if (n >= max)
      begin
        nFail++;
        $display("BAD %0t wait ran out", $time);
        conclude();
      end
    end
  endtask : limit

  task automatic cfg(input logic [7:0] r, input logic [4:0] keys);
    begin
      @(posedge clk);
      {reqPaged, entryInvalid, lookupEnable, cacheLoadQualifier, cachePresent,
        busDiagFlag, anyValidMatch, legacyPaging} <= r;
      entryKeys <= keys;
      reqNeedPublic <= 1'b0;
      victimHasDirty <= 1'b0;
    end
  endtask : cfg

  task automatic run(output int n);
    begin
      @(negedge clk);
      seen = '0;
      holdSeen = '0;
      holdCnt = 0;
      @(posedge clk);
      writeReq <= 1'b1;
      @(posedge clk);
      writeReq <= 1'b0;
      n = 1;
      while (responseSignal !== 1'b1 && n < 500)
      begin
        @(posedge clk);
        #1;
        n++;
        if (n == 2)
          `CHK({cycleLatch, reqPending}, 2'h1)
        if (n == 3)
          `CHK({cycleLatch, reqPending}, 2'h2)
      end
      limit(n, 500);
      repeat (2) @(posedge clk);
      #1;
    end
  endtask : run

  task automatic waitAck();
    int k;
    begin
      k = 0;
      while (coreCycleActive !== 1'b0 && k < 100)
      begin
        @(posedge clk);
        #1;
        k++;
      end
      limit(k, 100);
    end
  endtask : waitAck

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic scHit();
    begin
      cfg(8'hba, 5'h17);
      run(lat);
      `CHK(lat, LAT_HIT)
      `CHK(seen, 11'h007)
      `CHK(physicalAddr, {entryPhysPage, virtualAddr[PAGE_W-1:0]})
      `CHK(lookupIndex, virtualAddr)
      cfg(8'hba, 5'h17);
      coreFillSameLine <= 1'b1;
      fork
        run(lat);
        begin
          repeat (30) @(posedge clk);
          #1;
          `CHK(seen[0], 1'b0)
          @(posedge clk);
          coreFillSameLine <= 1'b0;
        end
      join
      `CHK(lat > 30, 1'b1)
      `CHK(seen, 11'h007)
    end
  endtask : scHit

  task automatic scClear();
    begin
      cfg(8'hb8, 5'h17);
      run(lat);
      `CHK(lat, LAT_CLR)
      `CHK(seen, 11'h03f)
      cfg(8'hb8, 5'h17);
      victimHasDirty <= 1'b1;
      fork
        run(lat);
        begin
          repeat (12) @(posedge clk);
          victimHasDirty <= 1'b0;
        end
      join
      `CHK(seen, 11'h07f)
      cfg(8'hb8, 5'h17);
      coreFillSameLine <= 1'b1;
      fork
        run(lat);
        begin
          repeat (20) @(posedge clk);
          #1;
          `CHK(seen[3], 1'b0)
          @(posedge clk);
          coreFillSameLine <= 1'b0;
        end
      join
      `CHK(lat > 20, 1'b1)
      `CHK(seen, 11'h03f)
    end
  endtask : scClear

  task automatic scRoute();
    logic [8:0] rIn [9];
    logic [10:0] rExp [9];
    begin
      rIn = '{9'h1ba, 9'h1aa, 9'h1a8, 9'h18a, 9'h0ba, 9'h0b8, 9'h1be, 9'h1b2,
        9'h07a};
      rExp = '{11'h007, 11'h007, 11'h600, 11'h600, 11'h007, 11'h600, 11'h600,
        11'h600, 11'h007};
      for (int i = 0; i < 9; i++)
      begin
        cfg(rIn[i][7:0], {rIn[i][8], {4{rIn[i][7]}} & 4'h7});
        virtualAddr <= {virtualAddr[VADDR_W-1:2], i[1:0]};
        ackDelay <= i[0] ? 8'h28 : 8'h05;
        run(lat);
        `CHK(seen, rExp[i])
        if (i == 8)
          `CHK(physicalAddr, {9'h000, virtualAddr})
        if (rExp[i][9])
        begin
          `CHK(holdSeen, 4'h1 << i[1:0])
          `CHK(holdCnt, 1)
          `CHK(bufferSelect, i[1:0])
          `CHK(coreCycleActive, 1'b1)
          waitAck();
        end
      end
    end
  endtask : scRoute

  task automatic scFault();
    logic [5:0] k [4];
    begin
      k = '{6'h16, 6'h15, 6'h33, 6'h13};
      for (int i = 0; i < 4; i++)
      begin
        cfg(8'hba, k[i][4:0]);
        reqNeedPublic <= k[i][5];
        faultWord <= {32'h0a5c3e70, i[3:0]};
        run(lat);
        `CHK(faultHold, i < 3)
        `CHK(seen, (i < 3) ? 11'h100 : 11'h007)
        `CHK(busRegister, {32'h0a5c3e70, (i < 3) ? i[3:0] : 4'h2})
      end
      cfg(8'hba, 5'h17);
      entryUser <= 1'b0;
      run(lat);
      `CHK({faultHold, faultHandleSignal}, 2'h3)
      `CHK(seen, 11'h100)
      `CHK(busRegister, faultWord)
      cfg(8'hfb, 5'h17);
      entryUser <= 1'b1;
      run(lat);
      `CHK({faultHold, faultHandleSignal}, 2'h2)
      `CHK(seen, 11'h180)
    end
  endtask : scFault

  task automatic scBusy();
    begin
      cfg(8'h8a, 5'h17);
      coreBusy <= 1'b1;
      fork
        run(lat);
        begin
          repeat (25) @(posedge clk);
          #1;
          `CHK(seen[9], 1'b0)
          @(posedge clk);
          coreBusy <= 1'b0;
        end
      join
      `CHK(seen, 11'h600)
      waitAck();
    end
  endtask : scBusy

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    {writeReq, reqPaged, reqNeedPublic, legacyPaging, busDiagFlag} = 5'h00;
    {lookupEnable, cacheLoadQualifier, cachePresent, userSpaceFlag} = 4'hf;
    {entryInvalid, anyValidMatch, victimHasDirty, coreFillSameLine} = 4'h0;
    coreBusy = 1'b0;
    entryUser = 1'b1;
    virtualAddr = 27'h2c3d5e6;
    entrySect = 5'h0b;
    entryPhysPage = 27'h5b1c2d3;
    entryKeys = 5'h17;
    faultWord = 36'h0a5c3e700;
    ackDelay = 8'h05;
    nFail = 0;
    totalChecks = 0;
    repeat (16) @(posedge clk);
    `CHK(bufferHold, 4'hf)
    sys_rst <= 1'b0;
    scHit();
    scClear();
    scRoute();
    scFault();
    scBusy();
    conclude();
  end
endmodule : tb_top
